// file: hdl/csw_pkg.sv
// package with register map, field positions and timing for the clock switch block
package csw_pkg;
	// register word addresses
	localparam logic [3:0] ADDR_OSC_CTRL = 4'h0; // oscillator_control_reg
	localparam logic [3:0] ADDR_RC_TUNE = 4'h1; // internal_rc_tune_reg
	localparam logic [3:0] ADDR_CLK_DIV = 4'h2; // sys_clock_divider
	localparam logic [3:0] ADDR_STATUS = 4'h3; // readiness and usb clock status
	localparam logic [3:0] ADDR_TUNE_MEAS = 4'h4; // frequency error input from the reference counter
	// unlock keys
	localparam logic [7:0] KEY_HI_A = 8'h78;
	localparam logic [7:0] KEY_HI_B = 8'h9a;
	localparam logic [7:0] KEY_LO_A = 8'h46;
	localparam logic [7:0] KEY_LO_B = 8'h57;
	// control register field positions
	localparam int CUR_SEL_LSB = 12;
	localparam int NEXT_SEL_LSB = 8;
	localparam int PLL_LOCK_BIT = 5;
	localparam int CLK_FAIL_BIT = 3;
	localparam int SECONDARY_32K_OSC_EN_BIT = 1;
	localparam int SWITCH_GO_BIT = 0;
	// tune register field positions
	localparam int ST_EN_BIT = 15;
	localparam int ST_REF_BIT = 12;
	localparam int ST_TOL_BIT = 11;
	localparam int ST_TOLPOL_BIT = 10;
	localparam int ST_OOR_BIT = 9;
	localparam int ST_OORPOL_BIT = 8;
	// reset values
	localparam logic [5:0] TRIM_RST = 6'h00;
	localparam logic [1:0] DIV_RST = 2'h0;
	// handover count of new-source cycles
	localparam logic [3:0] HANDOVER_CYCLES = 4'ha;
	// deviation limits in tenths of a percent of the measured error
	localparam logic [7:0] TOL_LIMIT = 8'h02; // 0.2 %
	localparam logic [7:0] RANGE_LIMIT = 8'h0f; // 1.5 %
	// self-tune step interval in system cycles
	localparam int STEP_NS = 1000;
	localparam int CLK_NS = 10;
	localparam logic [7:0] STEP_CYCLES = 8'(STEP_NS / CLK_NS);
	// usb pll clock tree figures in MHz
	localparam int PRESCALE_OUT_MHZ = 4;
	localparam int VCO_MHZ = 96;
	localparam int USB_MHZ = VCO_MHZ / 2;
	localparam int SYS_BASE_MHZ = VCO_MHZ / 3;
	// source selection codes
	typedef enum logic [2:0] {
		SRC_FRC = 3'b000,
		SRC_FRC_PLL = 3'b001,
		SRC_PRI = 3'b010,
		SRC_PRI_PLL = 3'b011,
		SRC_SECONDARY_32K_OSC = 3'b100,
		SRC_LOW_POWER_INTERNAL_RC = 3'b101,
		SRC_RSVD = 3'b110,
		SRC_FRC_DIV = 3'b111
	} csw_src_t;
	// switch sequencer states
	typedef enum logic [2:0] {
		SW_IDLE = 3'b000,
		SW_CHECK = 3'b001,
		SW_START = 3'b010,
		SW_WAIT_RDY = 3'b011,
		SW_HANDOVER = 3'b100,
		SW_DONE = 3'b101
	} csw_sw_state_t;
endpackage

// file: hdl/csw_tune_if.sv
// interface carrying the self-tune controls and results
`timescale 1ns/1ps
`default_nettype none
interface csw_tune_if;
	logic enable;
	logic ref_sel;
	logic ref_ok;
	logic signed [7:0] error;
	logic tol_ok;
	logic out_of_range;
	logic trim_we;
	logic [5:0] trim_wdata;
	logic [5:0] trim;
	modport ctrl (output enable, output ref_sel, output ref_ok, output error, output trim_we, output trim_wdata,
		input tol_ok, input out_of_range, input trim);
	modport tuner (input enable, input ref_sel, input ref_ok, input error, input trim_we, input trim_wdata,
		output tol_ok, output out_of_range, output trim);
endinterface
`default_nettype wire

// file: hdl/csw_selftune.sv
// self-tune loop stepping the internal rc trim toward the reference
`timescale 1ns/1ps
`default_nettype none
module csw_selftune
	import csw_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	csw_tune_if.tuner tif
);
	typedef struct packed {
		logic [5:0] trim;
		logic [7:0] tick;
		logic tol_ok;
		logic oor;
	} csw_tune_state_t;
	csw_tune_state_t st_r, st_nxt;
	logic [7:0] mag;

	// magnitude of the measured error
	always_comb begin
		mag = tif.error[7] ? 8'(-tif.error) : 8'(tif.error);
	end

	// trim stepping and status
	always_comb begin
		st_nxt = st_r;
		if (tif.enable) begin
			st_nxt.tick = (st_r.tick == STEP_CYCLES - 8'h01) ? 8'h00 : st_r.tick + 8'h01;
			if (tif.ref_ok && st_r.tick == 8'h00) begin
				st_nxt.tol_ok = (mag <= TOL_LIMIT);
				st_nxt.oor = 1'b0;
				if (mag > TOL_LIMIT) begin
					if (tif.error[7] && st_r.trim != 6'h1f) begin
						st_nxt.trim = st_r.trim + 6'h01;
					end else if (!tif.error[7] && st_r.trim != 6'h20) begin
						st_nxt.trim = st_r.trim - 6'h01;
					end else begin
						st_nxt.oor = (mag > RANGE_LIMIT);
					end
				end
				if (mag > RANGE_LIMIT) begin
					st_nxt.oor = 1'b1;
				end
			end
		end else begin
			st_nxt.tick = 8'h00;
			st_nxt.tol_ok = 1'b0;
			st_nxt.oor = 1'b0;
			if (tif.trim_we) begin
				st_nxt.trim = tif.trim_wdata;
			end
		end
	end

	// state register
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			st_r <= '{trim: TRIM_RST, tick: 8'h00, tol_ok: 1'b0, oor: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign tif.trim = st_r.trim;
	assign tif.tol_ok = st_r.tol_ok;
	assign tif.out_of_range = st_r.oor;

	a_trim_frozen_write: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		tif.enable && tif.trim_we && !(tif.ref_ok && st_r.tick == 8'h00) |=> $stable(st_r.trim))
		else $error("trim written while self-tune active");
	a_range_flag_src: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		$rose(st_r.oor) |-> $past(tif.enable))
		else $error("out of range set without self-tune");
endmodule
`default_nettype wire

// file: hdl/csw_clock_switch.sv
// oscillator control: protected clock switch, self-tune control and usb clock tree state
// Function
// - switch and fail-safe monitor enabled only when configuration bit is zero
// - with switching disabled ignore next-source, hold go at zero, show default source
// - redundant request with equal sources clears go and aborts
// - valid request clears pll lock and clock fail flags
// - start new oscillator, wait startup timer or pll lock
// - count ten new-clock cycles before handover
// - on completion clear go and copy next into current source
// - turn old source off, keeping low_power_internal_rc or secondary when needed
// - primary submode fixed by configuration, not changed by switching
// - self-tune enable bit starts calibration, reference bit picks usb or 32k
// - active self-tune adjusts six-bit trim and blocks software writes
// - interrupt on drift over 0.2% or uncorrectable over 1.5%, two status bits
// - polarity bits pick presence or absence, meaningless when disabled
// - 48 MHz usb clock provided while usb enabled and not suspended, here only while a pll source is selected
// - prescale to 4 MHz, multiply to 96, divide by 2 and by 3
// - divider codes give 32, 16, 8, 4 MHz; slow codes only without usb
// - source encodings 000 to 111 as listed, 110 reserved
//
// Added by the designer: strobed register access and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module csw_clock_switch
	import csw_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic reset_n_i,
	input wire logic switch_monitor_disable_cfg_i,
	input wire logic [2:0] default_source_cfg_i,
	input wire logic [1:0] primary_submode_cfg_i,
	input wire logic watchdog_en_i,
	input wire logic startup_timer_done_i,
	input wire logic pll_locked_i,
	input wire logic new_clk_tick_i,
	input wire logic usb_enabled_i,
	input wire logic usb_suspended_i,
	input wire logic sof_ref_ok_i,
	input wire logic secondary_32k_osc_ref_ok_i,
	input wire logic [3:0] reg_addr_i,
	input wire logic [15:0] reg_wdata_i,
	input wire logic [1:0] reg_byte_en_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	output logic [15:0] reg_rdata_o,
	output logic [7:0] osc_enable_o,
	output logic [2:0] sys_clk_source_o,
	output logic [5:0] frc_trim_bits_o,
	output logic selftune_irq_flag_o,
	output logic usb_clk_enable_o,
	output logic [1:0] sys_clock_divider_o,
	output logic [1:0] primary_submode_o
);
	typedef struct packed {
		csw_sw_state_t state;
		logic [2:0] cur_sel;
		logic [2:0] next_sel;
		logic go;
		logic pll_lock;
		logic clk_fail;
		logic secondary_32k_osc_en;
		logic [1:0] hi_key;
		logic [1:0] lo_key;
		logic [3:0] hand_cnt;
		logic [7:0] osc_on;
		logic st_en;
		logic st_ref;
		logic tol_pol;
		logic oor_pol;
		logic [1:0] div;
		logic signed [7:0] err;
		logic irq;
		logic usb_clk;
		logic [15:0] rdata;
		logic [1:0] submode;
		logic init_done;
	} csw_state_t;
	csw_state_t s_r, s_nxt;
	csw_tune_if tif ();
	logic sw_enabled;
	logic wr_hi, wr_lo;

	// switching available only with the configuration bit at zero
	assign sw_enabled = !switch_monitor_disable_cfg_i;
	assign wr_hi = reg_wr_i && reg_addr_i == ADDR_OSC_CTRL && reg_byte_en_i[1];
	assign wr_lo = reg_wr_i && reg_addr_i == ADDR_OSC_CTRL && reg_byte_en_i[0];

	// one-hot enable for a source code
	function automatic logic [7:0] src_bit(input logic [2:0] code);
		src_bit = 8'h01 << code;
	endfunction

	// true when the source uses the pll
	function automatic logic src_is_pll(input logic [2:0] code);
		src_is_pll = (code == SRC_PRI_PLL) || (code == SRC_FRC_PLL);
	endfunction

	// next-state logic
	always_comb begin
		s_nxt = s_r;
		s_nxt.rdata = 16'h0000;
		// capture configuration after reset release
		if (!s_r.init_done) begin
			s_nxt.init_done = 1'b1;
			s_nxt.cur_sel = default_source_cfg_i;
			s_nxt.next_sel = default_source_cfg_i;
			s_nxt.osc_on = src_bit(default_source_cfg_i);
			s_nxt.submode = primary_submode_cfg_i;
		end
		// unlock key tracking; any other access cancels
		if (reg_wr_i || reg_rd_i) begin
			s_nxt.hi_key = 2'h0;
			s_nxt.lo_key = 2'h0;
		end
		if (wr_hi) begin
			if (s_r.hi_key == 2'h2) begin
				if (sw_enabled && s_r.state == SW_IDLE) begin
					s_nxt.next_sel = reg_wdata_i[NEXT_SEL_LSB +: 3];
				end
			end else if (reg_wdata_i[15:8] == KEY_HI_A && !wr_lo) begin
				s_nxt.hi_key = 2'h1;
			end else if (s_r.hi_key == 2'h1 && reg_wdata_i[15:8] == KEY_HI_B && !wr_lo) begin
				s_nxt.hi_key = 2'h2;
			end
		end
		if (wr_lo) begin
			if (s_r.lo_key == 2'h2) begin
				s_nxt.secondary_32k_osc_en = reg_wdata_i[SECONDARY_32K_OSC_EN_BIT];
				if (!reg_wdata_i[CLK_FAIL_BIT]) begin
					s_nxt.clk_fail = 1'b0; // clear-only bit
				end
				if (reg_wdata_i[SWITCH_GO_BIT] && sw_enabled && s_r.state == SW_IDLE) begin
					s_nxt.go = 1'b1;
					s_nxt.state = SW_CHECK;
				end
			end else if (reg_wdata_i[7:0] == KEY_LO_A && !wr_hi) begin
				s_nxt.lo_key = 2'h1;
			end else if (s_r.lo_key == 2'h1 && reg_wdata_i[7:0] == KEY_LO_B && !wr_hi) begin
				s_nxt.lo_key = 2'h2;
			end
		end
		// self-tune and divider registers
		if (reg_wr_i && reg_addr_i == ADDR_RC_TUNE) begin
			s_nxt.st_en = reg_wdata_i[ST_EN_BIT];
			s_nxt.st_ref = reg_wdata_i[ST_REF_BIT];
			s_nxt.tol_pol = reg_wdata_i[ST_TOLPOL_BIT];
			s_nxt.oor_pol = reg_wdata_i[ST_OORPOL_BIT];
		end
		if (reg_wr_i && reg_addr_i == ADDR_CLK_DIV) begin
			if (!usb_enabled_i || !reg_wdata_i[1]) begin
				s_nxt.div = reg_wdata_i[1:0];
			end
		end
		if (reg_wr_i && reg_addr_i == ADDR_TUNE_MEAS) begin
			s_nxt.err = reg_wdata_i[7:0];
		end
		// switch sequencer
		case (s_r.state)
			SW_IDLE: begin
				s_nxt.hand_cnt = 4'h0;
			end
			SW_CHECK: begin
				if (s_r.next_sel == s_r.cur_sel) begin
					s_nxt.go = 1'b0;
					s_nxt.state = SW_IDLE;
				end else begin
					s_nxt.pll_lock = 1'b0;
					s_nxt.clk_fail = 1'b0;
					s_nxt.state = SW_START;
				end
			end
			SW_START: begin
				s_nxt.osc_on = s_r.osc_on | src_bit(s_r.next_sel);
				s_nxt.state = SW_WAIT_RDY;
			end
			SW_WAIT_RDY: begin
				if (src_is_pll(s_r.next_sel)) begin
					if (pll_locked_i) begin
						s_nxt.pll_lock = 1'b1;
						s_nxt.state = SW_HANDOVER;
					end
				end else if (s_r.next_sel == SRC_PRI || s_r.next_sel == SRC_SECONDARY_32K_OSC) begin
					if (startup_timer_done_i) begin
						s_nxt.state = SW_HANDOVER;
					end
				end else begin
					// rc sources run at once and need no start-up wait
					s_nxt.state = SW_HANDOVER;
				end
			end
			SW_HANDOVER: begin
				// ticks seen while still waiting for readiness are not counted
				if (new_clk_tick_i) begin
					s_nxt.hand_cnt = s_r.hand_cnt + 4'h1;
					if (s_r.hand_cnt == HANDOVER_CYCLES - 4'h1) begin
						s_nxt.state = SW_DONE;
					end
				end
			end
			SW_DONE: begin
				s_nxt.go = 1'b0;
				s_nxt.cur_sel = s_r.next_sel;
				s_nxt.osc_on = src_bit(s_r.next_sel);
				if (watchdog_en_i || sw_enabled) begin
					s_nxt.osc_on[SRC_LOW_POWER_INTERNAL_RC] = 1'b1;
				end
				if (s_r.secondary_32k_osc_en) begin
					s_nxt.osc_on[SRC_SECONDARY_32K_OSC] = 1'b1;
				end
				// a pll source keeps only its own input oscillator
				if (src_is_pll(s_r.next_sel)) begin
					s_nxt.osc_on[SRC_FRC] = (s_r.next_sel == SRC_FRC_PLL);
					s_nxt.osc_on[SRC_PRI] = (s_r.next_sel == SRC_PRI_PLL);
				end
				s_nxt.state = SW_IDLE;
			end
			default: begin
				s_nxt.state = SW_IDLE;
			end
		endcase
		if (!src_is_pll(s_r.cur_sel) && s_r.state == SW_IDLE) begin
			s_nxt.pll_lock = 1'b0;
		end
		// disabled switching: default source and idle go
		if (!sw_enabled) begin
			s_nxt.go = 1'b0;
			s_nxt.state = SW_IDLE;
			s_nxt.cur_sel = default_source_cfg_i;
			s_nxt.clk_fail = 1'b0;
		end
		// self-tune interrupt with polarity selection
		s_nxt.irq = s_r.st_en && ((tif.tol_ok ~^ s_r.tol_pol) || (tif.out_of_range ~^ s_r.oor_pol));
		// usb clock tree availability
		s_nxt.usb_clk = usb_enabled_i && !usb_suspended_i && src_is_pll(s_r.cur_sel);
		// read decode
		if (reg_rd_i) begin
			if (reg_addr_i == ADDR_OSC_CTRL) begin
				s_nxt.rdata = {1'b0, s_r.cur_sel, 1'b0, s_r.next_sel, 2'h0, s_r.pll_lock, 1'b0, s_r.clk_fail,
					1'b0, s_r.secondary_32k_osc_en, s_r.go};
			end else if (reg_addr_i == ADDR_RC_TUNE) begin
				s_nxt.rdata = {s_r.st_en, 2'h0, s_r.st_ref, tif.tol_ok, s_r.tol_pol, tif.out_of_range,
					s_r.oor_pol, 2'h0, tif.trim};
			end else if (reg_addr_i == ADDR_CLK_DIV) begin
				s_nxt.rdata = {14'h0000, s_r.div};
			end else if (reg_addr_i == ADDR_STATUS) begin
				s_nxt.rdata = {s_r.submode, s_r.usb_clk, s_r.state, s_r.osc_on, 2'h0};
			end else begin
				s_nxt.rdata = 16'h0000;
			end
		end
	end

	// state register
	always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			s_r <= '0;
		end else begin
			s_r <= s_nxt;
		end
	end

	// self-tune controls toward the loop
	assign tif.enable = s_r.st_en;
	assign tif.ref_sel = s_r.st_ref;
	assign tif.ref_ok = s_r.st_ref ? sof_ref_ok_i : secondary_32k_osc_ref_ok_i;
	assign tif.error = s_r.err;
	assign tif.trim_we = reg_wr_i && reg_addr_i == ADDR_RC_TUNE;
	assign tif.trim_wdata = reg_wdata_i[5:0];

	csw_selftune csw_selftune_i (
		.ref_clk_i(ref_clk_i),
		.reset_n_i(reset_n_i),
		.tif(tif)
	);

	// outputs straight from state
	assign reg_rdata_o = s_r.rdata;
	assign osc_enable_o = s_r.osc_on;
	assign sys_clk_source_o = s_r.cur_sel;
	assign frc_trim_bits_o = tif.trim;
	assign selftune_irq_flag_o = s_r.irq;
	assign usb_clk_enable_o = s_r.usb_clk;
	assign sys_clock_divider_o = s_r.div;
	assign primary_submode_o = s_r.submode;

	// sequencer, unlock, divider and self-tune irq checks
	a_disabled_go_low: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		!sw_enabled |=> !s_r.go)
		else $error("go set while switching disabled");
	a_redundant_abort: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		s_r.state == SW_CHECK && s_r.next_sel == s_r.cur_sel && sw_enabled |=> !s_r.go && s_r.state == SW_IDLE)
		else $error("redundant switch not aborted");
	a_valid_clear_flags: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		s_r.state == SW_CHECK && s_r.next_sel != s_r.cur_sel && sw_enabled |=> !s_r.pll_lock && !s_r.clk_fail)
		else $error("flags not cleared on valid switch");
	a_pll_wait: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		s_r.state == SW_WAIT_RDY && src_is_pll(s_r.next_sel) && !pll_locked_i && sw_enabled
		|=> s_r.state == SW_WAIT_RDY)
		else $error("left pll wait without lock");
	a_handover_count: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		$rose(s_r.state == SW_DONE) |-> $past(s_r.hand_cnt) == HANDOVER_CYCLES - 4'h1)
		else $error("handover count wrong");
	a_done_copy: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		s_r.state == SW_DONE && sw_enabled |=> s_r.cur_sel == $past(s_r.next_sel) && !s_r.go)
		else $error("switch completion wrong");
	a_unlocked_ignored: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		wr_hi && s_r.hi_key != 2'h2 && s_r.init_done |=> s_r.next_sel == $past(s_r.next_sel))
		else $error("selection written without unlock");
	a_slow_div_usb: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		reg_wr_i && reg_addr_i == ADDR_CLK_DIV && usb_enabled_i && reg_wdata_i[1] |=> $stable(s_r.div))
		else $error("slow divider accepted with usb on");
	a_irq_disabled: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		!s_r.st_en |=> !s_r.irq)
		else $error("self-tune irq while disabled");
	// completion and clock tree checks
	a_start_turns_on: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		s_r.state == SW_START && sw_enabled |=> s_r.osc_on[s_r.next_sel])
		else $error("new source not started");
	a_low_power_internal_rc_kept: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		s_r.state == SW_DONE && sw_enabled |=> s_r.osc_on[SRC_LOW_POWER_INTERNAL_RC])
		else $error("low-power rc stopped while monitor enabled");
	a_old_source_off: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		s_r.state == SW_DONE && sw_enabled && !src_is_pll(s_r.next_sel) && s_r.cur_sel != SRC_LOW_POWER_INTERNAL_RC
		&& s_r.cur_sel != SRC_SECONDARY_32K_OSC |=> (s_r.osc_on & src_bit($past(s_r.cur_sel))) == 8'h00)
		else $error("old source left running");
	a_default_tracked: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		!sw_enabled |=> s_r.cur_sel == $past(default_source_cfg_i))
		else $error("current source not following default while disabled");
	a_usb_clk_on: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		usb_enabled_i && !usb_suspended_i && src_is_pll(s_r.cur_sel) |=> s_r.usb_clk)
		else $error("usb clock missing while usb active");
	// coverage of the main scenarios
	c_pll_wait: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		s_r.state == SW_WAIT_RDY && src_is_pll(s_r.next_sel) && !pll_locked_i);
	c_div_refused: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		reg_wr_i && reg_addr_i == ADDR_CLK_DIV && usb_enabled_i && reg_wdata_i[1]);
	c_switch_done: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i) s_r.state == SW_DONE);
	c_redundant: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i)
		s_r.state == SW_CHECK && s_r.next_sel == s_r.cur_sel);
	c_tune_irq: cover property (@(posedge ref_clk_i) disable iff (!reset_n_i) $rose(s_r.irq));
endmodule
`default_nettype wire

// file: verif/csw_clock_switch_tb.sv
// self-checking bench for the clock switch and self-tune block
`timescale 1ns/1ps
`default_nettype none
// compares 1 ns after the edge so that registered outputs have settled
`define CHK(nm, ex, got) begin #1; checked++; if ((got) !== (ex)) begin bad_count++; \
	$display("[FAIL] %s expected %h seen %h", nm, ex, got); end end
module csw_clock_switch_tb
	import csw_pkg::*;
;
	logic ref_clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic cfg_dis = 1'b1;
	logic [2:0] dflt = SRC_FRC;
	logic [1:0] subm = 2'h1;
	logic wdt_en = 1'b0, ost_done = 1'b0, pll_lk = 1'b0, tick = 1'b0;
	logic usb_en = 1'b0, usb_susp = 1'b0, sof_ok = 1'b0, secondary_32k_osc_ok = 1'b1;
	logic [3:0] reg_addr_i = 4'h0;
	logic [15:0] reg_wdata_i = 16'h0000;
	logic [1:0] reg_byte_en_i = 2'h3;
	logic reg_wr_i = 1'b0, reg_rd_i = 1'b0;
	logic [15:0] reg_rdata_o, v;
	logic [7:0] osc_enable_o;
	logic [2:0] sys_clk_source_o;
	logic [5:0] frc_trim_bits_o;
	logic selftune_irq_flag_o, usb_clk_enable_o;
	logic [1:0] sys_clock_divider_o, primary_submode_o;
	int bad_count = 0;
	int checked = 0;
	// error, tolerance polarity, range polarity, expected flag
	logic [10:0] tcase [4] = '{{8'h05, 3'b110}, {8'h05, 3'b011}, {8'h14, 3'b100}, {8'h14, 3'b111}};

	csw_clock_switch csw_clock_switch_i (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
		.switch_monitor_disable_cfg_i(cfg_dis), .default_source_cfg_i(dflt), .primary_submode_cfg_i(subm),
		.watchdog_en_i(wdt_en), .startup_timer_done_i(ost_done), .pll_locked_i(pll_lk),
		.new_clk_tick_i(tick), .usb_enabled_i(usb_en), .usb_suspended_i(usb_susp),
		.sof_ref_ok_i(sof_ok), .secondary_32k_osc_ref_ok_i(secondary_32k_osc_ok), .reg_addr_i(reg_addr_i),
		.reg_wdata_i(reg_wdata_i), .reg_byte_en_i(reg_byte_en_i), .reg_wr_i(reg_wr_i),
		.reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .osc_enable_o(osc_enable_o),
		.sys_clk_source_o(sys_clk_source_o), .frc_trim_bits_o(frc_trim_bits_o),
		.selftune_irq_flag_o(selftune_irq_flag_o), .usb_clk_enable_o(usb_clk_enable_o),
		.sys_clock_divider_o(sys_clock_divider_o), .primary_submode_o(primary_submode_o));

	// 100 MHz clock
	initial begin
		forever #5 ref_clk_i = ~ref_clk_i;
	end

	// back-to-back writes of n words, strobe held high between them
	task automatic wr(input logic [3:0] a, input logic [1:0] be, input logic [15:0] d0, d1, d2, input int n);
		for (int i = 0; i < n; i++) begin
			reg_wr_i <= 1'b1;
			reg_addr_i <= a;
			reg_byte_en_i <= be;
			reg_wdata_i <= (i == 0) ? d0 : ((i == 1) ? d1 : d2);
			@(posedge ref_clk_i);
		end
		reg_wr_i <= 1'b0;
		@(posedge ref_clk_i);
	endtask

	// read strobe one cycle, data sampled in the following cycle
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		reg_rd_i <= 1'b1;
		reg_addr_i <= a;
		@(posedge ref_clk_i);
		reg_rd_i <= 1'b0;
		#1 d = reg_rdata_o;
		@(posedge ref_clk_i);
	endtask

	// both unlock sequences, new selection and go
	task automatic sw(input logic [2:0] s, input logic secondary_32k_osc);
		wr(ADDR_OSC_CTRL, 2'b10, {KEY_HI_A, 8'h00}, {KEY_HI_B, 8'h00}, {5'h00, s, 8'h00}, 3);
		wr(ADDR_OSC_CTRL, 2'b01, {8'h00, KEY_LO_A}, {8'h00, KEY_LO_B}, {14'h0000, secondary_32k_osc, 1'b1}, 3);
	endtask

	// single-cycle pulses of the new clock
	task automatic ticks(input int n);
		repeat (n) begin
			tick <= 1'b1;
			@(posedge ref_clk_i);
			tick <= 1'b0;
			@(posedge ref_clk_i);
		end
	endtask

	task automatic stop_test();
		if (bad_count == 0 && checked > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask

	// hang guard
	initial begin
		repeat (20000) @(posedge ref_clk_i);
		bad_count++;
		stop_test();
	end

	// main sequence
	initial begin
		repeat (6) @(posedge ref_clk_i);
		reset_n_i <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		`CHK("src_reset", SRC_FRC, sys_clk_source_o)
		dflt <= SRC_LOW_POWER_INTERNAL_RC;
		repeat (2) @(posedge ref_clk_i);
		`CHK("src_track", SRC_LOW_POWER_INTERNAL_RC, sys_clk_source_o)
		sw(SRC_PRI, 1'b0);
		rd(ADDR_OSC_CTRL, v);
		`CHK("go_disabled", 1'b0, v[SWITCH_GO_BIT])
		`CHK("cur_disabled", SRC_LOW_POWER_INTERNAL_RC, v[14:12])
		// enable switching from the internal rc
		dflt <= SRC_FRC;
		repeat (2) @(posedge ref_clk_i);
		cfg_dis <= 1'b0;
		repeat (2) @(posedge ref_clk_i);
		wr(ADDR_OSC_CTRL, 2'b10, {5'h00, SRC_PRI, 8'h00}, 16'h0, 16'h0, 1);
		rd(ADDR_OSC_CTRL, v);
		`CHK("next_locked", SRC_FRC, v[10:8])
		wr(ADDR_OSC_CTRL, 2'b10, {KEY_HI_A, 8'h00}, 16'h0, 16'h0, 1);
		rd(ADDR_OSC_CTRL, v);
		wr(ADDR_OSC_CTRL, 2'b10, {KEY_HI_B, 8'h00}, {5'h00, SRC_PRI, 8'h00}, 16'h0, 2);
		rd(ADDR_OSC_CTRL, v);
		`CHK("next_cancel", SRC_FRC, v[10:8])
		sw(SRC_FRC, 1'b0);
		repeat (3) @(posedge ref_clk_i);
		rd(ADDR_OSC_CTRL, v);
		`CHK("go_redundant", 1'b0, v[SWITCH_GO_BIT])
		// switch to primary: wait for start-up, then ten ticks
		pll_lk <= 1'b1;
		sw(SRC_PRI, 1'b1);
		ticks(12);
		rd(ADDR_OSC_CTRL, v);
		`CHK("go_waiting", 1'b1, v[SWITCH_GO_BIT])
		`CHK("lock_cleared", 1'b0, v[PLL_LOCK_BIT])
		`CHK("src_no_ost", SRC_FRC, sys_clk_source_o)
		ost_done <= 1'b1;
		@(posedge ref_clk_i);
		ticks(9);
		`CHK("src_nine", SRC_FRC, sys_clk_source_o)
		ticks(1);
		repeat (3) @(posedge ref_clk_i);
		`CHK("src_pri", SRC_PRI, sys_clk_source_o)
		rd(ADDR_OSC_CTRL, v);
		`CHK("cur_pri", {SRC_PRI, 1'b0}, {v[14:12], v[SWITCH_GO_BIT]})
		`CHK("frc_off", 1'b0, osc_enable_o[SRC_FRC])
		`CHK("secondary_32k_osc_kept", 1'b1, osc_enable_o[SRC_SECONDARY_32K_OSC])
		subm <= 2'h2;
		repeat (2) @(posedge ref_clk_i);
		`CHK("submode", 2'h1, primary_submode_o)
		// switch to primary with pll, held off by pll lock
		pll_lk <= 1'b0;
		sw(SRC_PRI_PLL, 1'b0);
		ticks(12);
		`CHK("src_no_lock", SRC_PRI, sys_clk_source_o)
		pll_lk <= 1'b1;
		@(posedge ref_clk_i);
		ticks(10);
		repeat (3) @(posedge ref_clk_i);
		`CHK("src_pll", SRC_PRI_PLL, sys_clk_source_o)
		usb_en <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		`CHK("usb_clk_on", 1'b1, usb_clk_enable_o)
		usb_susp <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		`CHK("usb_clk_susp", 1'b0, usb_clk_enable_o)
		// divider codes with and without usb
		wr(ADDR_CLK_DIV, 2'b11, 16'h0002, 16'h0, 16'h0, 1);
		rd(ADDR_CLK_DIV, v);
		`CHK("div_refused", DIV_RST, v[1:0])
		wr(ADDR_CLK_DIV, 2'b11, 16'h0001, 16'h0, 16'h0, 1);
		`CHK("div_one", 2'h1, sys_clock_divider_o)
		usb_en <= 1'b0;
		wr(ADDR_CLK_DIV, 2'b11, 16'h0003, 16'h0, 16'h0, 1);
		`CHK("div_three", 2'h3, sys_clock_divider_o)
		// trim writable only while self-tune is off
		wr(ADDR_RC_TUNE, 2'b11, 16'h0015, 16'h0, 16'h0, 1);
		`CHK("trim_sw", 6'h15, frc_trim_bits_o)
		wr(ADDR_TUNE_MEAS, 2'b11, 16'h0000, 16'h0, 16'h0, 1);
		wr(ADDR_RC_TUNE, 2'b11, 16'h8015, 16'h8003, 16'h0, 2);
		rd(ADDR_RC_TUNE, v);
		`CHK("trim_blocked", {1'b1, 6'h15}, {v[ST_EN_BIT], v[5:0]})
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_TUNE_MEAS, 2'b11, {8'h00, tcase[i][10:3]}, 16'h0, 16'h0, 1);
			wr(ADDR_RC_TUNE, 2'b11, {1'b1, 4'h0, tcase[i][2], 1'b0, tcase[i][1], 8'h00}, 16'h0, 16'h0, 1);
			repeat (250) @(posedge ref_clk_i);
			`CHK("irq_case", tcase[i][0], selftune_irq_flag_o)
			rd(ADDR_RC_TUNE, v);
			`CHK("tune_status", {1'b0, tcase[i][10:3] > RANGE_LIMIT}, {v[ST_TOL_BIT], v[ST_OOR_BIT]})
		end
		wr(ADDR_RC_TUNE, 2'b11, 16'h0000, 16'h0, 16'h0, 1);
		repeat (3) @(posedge ref_clk_i);
		`CHK("irq_off", 1'b0, selftune_irq_flag_o)
		stop_test();
	end
endmodule
`default_nettype wire
